// *** core/channel_pwm_and_fault_flags.sv ***
// Notes on behaviour
// - overcurrent flag latches, clears on read when gone
// - supply short flag latched, zero while check disabled
// - pull output low during supply short check while channel off
// - open load flag latched, zero while detection disabled
// - open load pull-up uses chosen strength
// - temperature warning latched, cleared on read below
// - three-bit rate field selects eight frequencies
// - eight-bit duty, about 0.39% per step
// - enable clear follows request, set modulates
// - modulation only with charge mode zero
// - no modulation during inrush after turn-on
// - charge mode 0 none, 2 limit, others unsupported
`timescale 1ns/1ps
`default_nettype none
module channel_pwm_and_fault_flags #(
  parameter int CLK_HZ = pwm_fault_pkg::CLK_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  // fault comparators and detection enables
  input wire logic overcurrentFault,
  input wire logic supplyShortFault,
  input wire logic offOpenLoadFault,
  input wire logic tempAboveWarning,
  input wire logic supplyShortCheckEnable,
  input wire logic openLoadCheckEnable,
  input wire logic [1:0] openLoadPullupStrength,
  // channel control
  input wire logic channelOnRequest,
  input wire logic [1:0] capChargeMode,
  input wire logic inrushActive,
  // outputs
  output logic channelDrive,
  output logic shortDetectPulldown,
  output logic openLoadPullupEnable,
  output logic [1:0] openLoadPullupLevel,
  output logic chargeModeUnsupported,
  output logic chargeLimitMode
);
  localparam int PRESCALE_W_L = pwm_fault_pkg::PRESCALE_W;

  logic [15:0] pwmControl_reg, pwmControl_next;
  logic [4:0] flags_reg, flags_next;
  logic [15:0] readData_reg, readData_next;
  logic [PRESCALE_W_L-1:0] prescale_reg, prescale_next;
  logic [7:0] phase_reg, phase_next;
  logic drive_reg, drive_next;
  logic pulldown_reg, pulldown_next;
  logic pullup_reg, pullup_next;
  logic [1:0] pullupLevel_reg, pullupLevel_next;
  logic unsupported_reg, unsupported_next;
  logic limitMode_reg, limitMode_next;

  // clock cycles per phase step for a rate code
  function automatic logic [PRESCALE_W_L-1:0] stepCycles(
    input logic [2:0] code
  );
    int mhz;
    case (code)
      3'h0: mhz = pwm_fault_pkg::RATE_MHZ_0;
      3'h1: mhz = pwm_fault_pkg::RATE_MHZ_1;
      3'h2: mhz = pwm_fault_pkg::RATE_MHZ_2;
      3'h3: mhz = pwm_fault_pkg::RATE_MHZ_3;
      3'h4: mhz = pwm_fault_pkg::RATE_MHZ_4;
      3'h5: mhz = pwm_fault_pkg::RATE_MHZ_5;
      3'h6: mhz = pwm_fault_pkg::RATE_MHZ_6;
      default: mhz = pwm_fault_pkg::RATE_MHZ_7;
    endcase
    stepCycles = PRESCALE_W_L'(
      (longint'(CLK_HZ) * 1000) / (longint'(mhz) * pwm_fault_pkg::PHASE_STEPS));
  endfunction : stepCycles

  // flag update: set wins over read clear
  function automatic logic latchFlag(input logic held, input logic cond,
                                     input logic rd);
    latchFlag = cond | (held & ~rd);
  endfunction : latchFlag

  logic statusRead;
  logic [2:0] rateCode;
  logic [7:0] dutyCode;
  logic modulate;
  logic pwmLevel;

  always_comb begin
    statusRead = regRead && regAddr == pwm_fault_pkg::FAULT_STATUS_ADDR;
    rateCode = pwmControl_reg[pwm_fault_pkg::RATE_MSB:pwm_fault_pkg::RATE_LSB];
    dutyCode = pwmControl_reg[pwm_fault_pkg::DUTY_MSB:pwm_fault_pkg::DUTY_LSB];
    modulate = pwmControl_reg[pwm_fault_pkg::ENABLE_BIT]
               && capChargeMode == pwm_fault_pkg::CHARGE_NONE
               && !inrushActive;
    // duty 0xFF gives full on
    pwmLevel = (phase_reg < dutyCode) || (dutyCode == 8'hFF);
  end

  // control register: only the low twelve bits are writable
  always_comb begin
    pwmControl_next = pwmControl_reg;
    if (regWrite && regAddr == pwm_fault_pkg::PWM_CONTROL_ADDR) begin
      pwmControl_next = (pwm_fault_pkg::PWM_CONTROL_RESET
                         & ~pwm_fault_pkg::PWM_CONTROL_RW_MASK)
                        | (regWriteData & pwm_fault_pkg::PWM_CONTROL_RW_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwmControl_reg <= pwm_fault_pkg::PWM_CONTROL_RESET;
    end else begin
      pwmControl_reg <= pwmControl_next;
    end
  end

  // fault flags, bit 1 reserved and held at zero
  always_comb begin
    flags_next[pwm_fault_pkg::OVERCURRENT_BIT] = latchFlag(
      flags_reg[pwm_fault_pkg::OVERCURRENT_BIT], overcurrentFault,
      statusRead);
    flags_next[pwm_fault_pkg::SUPPLY_SHORT_BIT] = supplyShortCheckEnable
      & latchFlag(flags_reg[pwm_fault_pkg::SUPPLY_SHORT_BIT],
                  supplyShortFault, statusRead);
    flags_next[pwm_fault_pkg::OPEN_LOAD_BIT] = openLoadCheckEnable
      & latchFlag(flags_reg[pwm_fault_pkg::OPEN_LOAD_BIT],
                  offOpenLoadFault, statusRead);
    flags_next[pwm_fault_pkg::TEMP_WARN_BIT] = latchFlag(
      flags_reg[pwm_fault_pkg::TEMP_WARN_BIT], tempAboveWarning,
      statusRead);
    flags_next[1] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= 5'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // read data holds until the next read
  always_comb begin
    readData_next = readData_reg;
    if (regRead) begin
      case (regAddr)
        pwm_fault_pkg::FAULT_STATUS_ADDR:
          readData_next = pwm_fault_pkg::FAULT_STATUS_RESET
                          | {11'h000, flags_reg};
        pwm_fault_pkg::PWM_CONTROL_ADDR: readData_next = pwmControl_reg;
        default: readData_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readData_reg <= 16'h0000;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // phase counter free-runs at 256x selected rate
  always_comb begin
    if (prescale_reg >= stepCycles(rateCode) - PRESCALE_W_L'(1)) begin
      prescale_next = '0;
      phase_next = phase_reg + 8'h01;
    end else begin
      prescale_next = prescale_reg + PRESCALE_W_L'(1);
      phase_next = phase_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prescale_reg <= '0;
      phase_reg <= 8'h00;
    end else begin
      prescale_reg <= prescale_next;
      phase_reg <= phase_next;
    end
  end

  // channel drive and detection pins
  always_comb begin
    drive_next = channelOnRequest && (!modulate || pwmLevel);
    pulldown_next = !channelOnRequest && supplyShortCheckEnable;
    pullup_next = !channelOnRequest && openLoadCheckEnable;
    pullupLevel_next = openLoadPullupStrength;
    unsupported_next = capChargeMode[0];
    limitMode_next = capChargeMode == pwm_fault_pkg::CHARGE_LIMIT;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_reg <= 1'b0;
      pulldown_reg <= 1'b0;
      pullup_reg <= 1'b0;
      pullupLevel_reg <= 2'h0;
      unsupported_reg <= 1'b0;
      limitMode_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      pulldown_reg <= pulldown_next;
      pullup_reg <= pullup_next;
      pullupLevel_reg <= pullupLevel_next;
      unsupported_reg <= unsupported_next;
      limitMode_reg <= limitMode_next;
    end
  end

  assign regReadData = readData_reg;
  assign channelDrive = drive_reg;
  assign shortDetectPulldown = pulldown_reg;
  assign openLoadPullupEnable = pullup_reg;
  assign openLoadPullupLevel = pullupLevel_reg;
  assign chargeModeUnsupported = unsupported_reg;
  assign chargeLimitMode = limitMode_reg;
endmodule : channel_pwm_and_fault_flags
`default_nettype wire

// *** include/pwm_fault_pkg.sv ***
package pwm_fault_pkg;
  // register offsets (serial register address)
  localparam logic [3:0] FAULT_STATUS_ADDR = 4'hD;
  localparam logic [3:0] PWM_CONTROL_ADDR = 4'hE;
  // fault status fields
  localparam int TEMP_WARN_BIT = 0;
  localparam int OPEN_LOAD_BIT = 2;
  localparam int SUPPLY_SHORT_BIT = 3;
  localparam int OVERCURRENT_BIT = 4;
  localparam logic [15:0] FAULT_STATUS_RESET = 16'hE000;
  // pwm control fields
  localparam int ENABLE_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int DUTY_MSB = 8;
  localparam int RATE_LSB = 9;
  localparam int RATE_MSB = 11;
  localparam logic [15:0] PWM_CONTROL_RESET = 16'hF000;
  localparam logic [15:0] PWM_CONTROL_RW_MASK = 16'h0FFF;
  // charge mode codes
  localparam logic [1:0] CHARGE_NONE = 2'h0;
  localparam logic [1:0] CHARGE_LIMIT = 2'h2;
  // clock and pwm timing
  localparam int CLK_HZ = 100_000_000;
  // rate table in milli-hertz, codes 0..7
  localparam int RATE_MHZ_0 = 800;
  localparam int RATE_MHZ_1 = 3400;
  localparam int RATE_MHZ_2 = 13800;
  localparam int RATE_MHZ_3 = 111000;
  localparam int RATE_MHZ_4 = 221000;
  localparam int RATE_MHZ_5 = 425000;
  localparam int RATE_MHZ_6 = 885000;
  localparam int RATE_MHZ_7 = 1770000;
  localparam int PHASE_STEPS = 256;
  localparam int PRESCALE_W = 20;
  // least pwm on-time, kept by software
  localparam int MIN_ON_US = 200;
  localparam int MIN_ON_CYCLES = (CLK_HZ / 1_000_000) * MIN_ON_US;
endpackage : pwm_fault_pkg

// *** verif/pwm_flags_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwm_flags_props (
  // watched ports
  input wire logic clk, rst, regRead, overcurrentFault, channelOnRequest,
  input wire logic supplyShortCheckEnable, openLoadCheckEnable, inrushActive,
  input wire logic channelDrive, shortDetectPulldown, openLoadPullupEnable,
  input wire logic chargeModeUnsupported, chargeLimitMode,
  input wire logic [1:0] openLoadPullupStrength, openLoadPullupLevel,
  input wire logic [1:0] capChargeMode,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regReadData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_lim; capChargeMode == 2'h2 |=> chargeLimitMode; endproperty
  a_lim: assert property (p_lim) else $error("limit mode");
  property p_uns; capChargeMode[0] |=> chargeModeUnsupported; endproperty
  a_uns: assert property (p_uns) else $error("unsupported mode");
  property p_pd; (!channelOnRequest && supplyShortCheckEnable)
    |=> shortDetectPulldown; endproperty
  a_pd: assert property (p_pd) else $error("pull-down off");
  property p_pu; (!channelOnRequest && openLoadCheckEnable) |=>
    openLoadPullupEnable && openLoadPullupLevel == $past(openLoadPullupStrength);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  property p_inr; inrushActive |=> channelDrive == $past(channelOnRequest);
  endproperty
  a_inr: assert property (p_inr) else $error("inrush drive");
  property p_mode; capChargeMode != 2'h0
    |=> channelDrive == $past(channelOnRequest); endproperty
  a_mode: assert property (p_mode) else $error("charge mode drive");
  property p_oc; overcurrentFault ##1 (overcurrentFault && regRead &&
    regAddr == 4'hD) |=> regReadData[4]; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent flag");
  property p_res; regRead && regAddr == 4'hE
    |=> regReadData[15:12] == 4'hF; endproperty
  a_res: assert property (p_res) else $error("reserved bits");
endmodule : pwm_flags_props
bind channel_pwm_and_fault_flags pwm_flags_props i_pwm_flags_props (
  .clk(clk),
  .rst(rst),
  .regRead(regRead),
  .overcurrentFault(overcurrentFault),
  .channelOnRequest(channelOnRequest),
  .supplyShortCheckEnable(supplyShortCheckEnable),
  .openLoadCheckEnable(openLoadCheckEnable),
  .inrushActive(inrushActive),
  .channelDrive(channelDrive),
  .shortDetectPulldown(shortDetectPulldown),
  .openLoadPullupEnable(openLoadPullupEnable),
  .chargeModeUnsupported(chargeModeUnsupported),
  .chargeLimitMode(chargeLimitMode),
  .openLoadPullupStrength(openLoadPullupStrength),
  .openLoadPullupLevel(openLoadPullupLevel),
  .capChargeMode(capChargeMode),
  .regAddr(regAddr),
  .regReadData(regReadData)
);
`default_nettype wire

// *** verif/host_serial_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // register port
  input wire logic clk,
  input wire logic [15:0] regReadData,
  output var logic regWrite, regRead,
  output var logic [3:0] regAddr,
  output var logic [15:0] regWriteData
);
  initial {regWrite, regRead, regAddr, regWriteData} = 22'h000000;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'h0;
    @(posedge clk);
    d = regReadData;
  endtask : rd
endmodule : host_serial_model
`default_nettype wire

// *** verif/channel_pwm_and_fault_flags_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module channel_pwm_and_fault_flags_test;
  logic clk, rst, regWrite, regRead, channelOnRequest, inrushActive;
  logic supplyShortCheckEnable, openLoadCheckEnable, channelDrive;
  logic shortDetectPulldown, openLoadPullupEnable, chargeModeUnsupported;
  logic chargeLimitMode, overcurrentFault, supplyShortFault;
  logic offOpenLoadFault, tempAboveWarning;
  logic [1:0] openLoadPullupStrength, capChargeMode, openLoadPullupLevel;
  logic [3:0] regAddr, flt;
  logic [15:0] regWriteData, regReadData, rdv;
  int badCount = 0;
  int checks = 0;
  int cyc = 0;
  longint stepC, onCnt;
  typedef struct packed {logic en; logic [7:0] duty; logic [1:0] mode;
    logic inr; logic req; logic exp;} row_t;
  row_t rows [9] = '{'{1'h0,8'h00,2'h0,1'h0,1'h1,1'h1},
    '{1'h0,8'hFF,2'h0,1'h0,1'h0,1'h0}, '{1'h1,8'hFF,2'h0,1'h0,1'h1,1'h1},
    '{1'h1,8'h00,2'h0,1'h0,1'h1,1'h0}, '{1'h1,8'h00,2'h2,1'h0,1'h1,1'h1},
    '{1'h1,8'h00,2'h3,1'h0,1'h1,1'h1}, '{1'h1,8'h00,2'h0,1'h1,1'h1,1'h1},
    '{1'h1,8'hFF,2'h0,1'h0,1'h0,1'h0}, '{1'h1,8'h00,2'h1,1'h0,1'h1,1'h1}};
  assign {overcurrentFault, supplyShortFault} = flt[3:2];
  assign {offOpenLoadFault, tempAboveWarning} = flt[1:0];
  channel_pwm_and_fault_flags i_channel_pwm_and_fault_flags (
    .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .overcurrentFault(overcurrentFault),
    .supplyShortFault(supplyShortFault),
    .offOpenLoadFault(offOpenLoadFault),
    .tempAboveWarning(tempAboveWarning),
    .supplyShortCheckEnable(supplyShortCheckEnable),
    .openLoadCheckEnable(openLoadCheckEnable),
    .openLoadPullupStrength(openLoadPullupStrength),
    .channelOnRequest(channelOnRequest), .capChargeMode(capChargeMode),
    .inrushActive(inrushActive), .channelDrive(channelDrive),
    .shortDetectPulldown(shortDetectPulldown),
    .openLoadPullupEnable(openLoadPullupEnable),
    .openLoadPullupLevel(openLoadPullupLevel),
    .chargeModeUnsupported(chargeModeUnsupported),
    .chargeLimitMode(chargeLimitMode)
  );
  host_serial_model i_host_serial_model (
    .clk(clk), .regReadData(regReadData), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData)
  );
  task automatic chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      badCount++;
      final_report();
    end
  end
  initial begin
    rst = 1'h1;
    flt = 4'h0;
    {channelOnRequest, inrushActive, capChargeMode} = 4'h0;
    {supplyShortCheckEnable, openLoadCheckEnable, openLoadPullupStrength} = 4'hE;
    repeat (20) @(posedge clk);
    chk("resetPins", {12'h000, shortDetectPulldown, openLoadPullupEnable,
      openLoadPullupLevel}, 16'h0000);
    rst <= 1'h0;
    i_host_serial_model.rd(4'hD, rdv);
    chk("statusReset", rdv, 16'hE000);
    i_host_serial_model.rd(4'hE, rdv);
    chk("controlReset", rdv, 16'hF000);
    chk("pins", {12'h000, shortDetectPulldown, openLoadPullupEnable,
      openLoadPullupLevel}, 16'h000E);
    $display("reset done");
    i_host_serial_model.rd(4'h3, rdv);
    chk("unmapped", rdv, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      i_host_serial_model.wr(4'hE, {4'h0, k[2:0], 9'h1FF});
      i_host_serial_model.rd(4'hE, rdv);
      chk("rate", rdv, {4'hF, k[2:0], 9'h1FF});
    end
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h1 << i;
      repeat (2) @(posedge clk);
      for (int r = 0; r < 4; r++) begin
        if (r == 2) flt <= 4'h0;
        i_host_serial_model.rd(4'hD, rdv);
        chk("flag", rdv, r == 3 ? 16'hE000 :
          16'hE000 | (16'h0001 << (i == 0 ? 0 : i + 1)));
      end
    end
    {supplyShortCheckEnable, openLoadCheckEnable} <= 2'h0;
    flt <= 4'h6;
    repeat (2) @(posedge clk);
    i_host_serial_model.rd(4'hD, rdv);
    chk("flagOff", rdv, 16'hE000);
    flt <= 4'h0;
    $display("fault flags done");
    foreach (rows[j]) begin
      i_host_serial_model.wr(4'hE, {7'h07, rows[j].duty, rows[j].en});
      {channelOnRequest, inrushActive} <= {rows[j].req, rows[j].inr};
      capChargeMode <= rows[j].mode;
      repeat (3) @(posedge clk);
      chk("drive", {15'h0000, channelDrive}, {15'h0000, rows[j].exp});
      chk("mode", {14'h0000, chargeLimitMode, chargeModeUnsupported},
        {14'h0000, rows[j].mode == 2'h2, rows[j].mode[0]});
    end
    stepC = longint'(pwm_fault_pkg::CLK_HZ) * 1000 /
      (longint'(pwm_fault_pkg::RATE_MHZ_7) * 256);
    onCnt = 0;
    i_host_serial_model.wr(4'hE, 16'h0F01);
    {channelOnRequest, inrushActive, capChargeMode} <= 4'h8;
    repeat (600) @(posedge clk);
    repeat (256 * stepC) @(posedge clk) onCnt += channelDrive;
    chk("onTime", onCnt[15:0], 16'(128 * stepC));
    $display("modulation done");
    final_report();
  end
endmodule : channel_pwm_and_fault_flags_test
`default_nettype wire
